// File: peepw_consts.svh
`ifndef PEEPW_CONSTS_SVH
`define PEEPW_CONSTS_SVH
`define PEEPW_CLK_NS 10
`define PEEPW_AW 13
`define PEEPW_DW 8
`define PEEPW_PAGE_LSB 6
`define PEEPW_PAGE_BYTES 64
`define PEEPW_POLL_BIT 7
`define PEEPW_TOGGLE_BIT 6
`define PEEPW_SETUP_NS 20
`define PEEPW_SETUP_CYC ((`PEEPW_SETUP_NS + `PEEPW_CLK_NS - 1) / `PEEPW_CLK_NS)
`define PEEPW_STROBE_NS 100
`define PEEPW_STROBE_CYC ((`PEEPW_STROBE_NS + `PEEPW_CLK_NS - 1) / `PEEPW_CLK_NS)
`define PEEPW_READ_NS 150
`define PEEPW_READ_CYC ((`PEEPW_READ_NS + `PEEPW_CLK_NS - 1) / `PEEPW_CLK_NS)
`define PEEPW_LOAD_US 100
`define PEEPW_LOAD_CYC ((`PEEPW_LOAD_US * 1000) / `PEEPW_CLK_NS)
`define PEEPW_LOAD_GUARD 500
`define PEEPW_WC_MS 2
`define PEEPW_WC_CYC ((`PEEPW_WC_MS * 1000000) / `PEEPW_CLK_NS)
`endif

// File: peepw_pkg.sv
package peepw_pkg;
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'h0,
    ST_SETUP = 3'h1,
    ST_STROBE = 3'h2,
    ST_HOLD = 3'h3,
    ST_POLL = 3'h4,
    ST_WAIT = 3'h5
  } peepw_state_e;
  typedef enum logic [1:0]
  {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_POLL = 2'h2
  } peepw_op_e;
  typedef struct packed
  {
    peepw_op_e op;
    logic [12:0] addr;
    logic [7:0] data;
    logic last;
  } peepw_req_s;
  typedef struct packed
  {
    logic [12:0] addr;
    logic [7:0] dataOut;
    logic dataOe;
    logic ceN;
    logic oeN;
    logic weN;
  } peepw_pins_s;
  typedef struct packed
  {
    logic [12:0] addr;
    logic [7:0] data;
  } peepw_step_s;
endpackage : peepw_pkg

// File: peepw_seq_rom.sv
`timescale 1ns/1ns
`include "peepw_consts.svh"
module peepw_seq_rom
#(
  parameter logic [12:0] UNLOCK_A0 = 13'h1555,
  parameter logic [12:0] UNLOCK_A1 = 13'h0AAA,
  parameter logic [7:0] UNLOCK_D0 = 8'hAA,
  parameter logic [7:0] UNLOCK_D1 = 8'h55,
  parameter logic [7:0] UNLOCK_D2 = 8'hA0,
  parameter logic [7:0] CLEAR_D2 = 8'h80,
  parameter logic [7:0] CLEAR_D5 = 8'h20
)
(
  input wire logic clear,
  input wire logic [2:0] idx,
  output peepw_pkg::peepw_step_s step
);
  // Sequence step table, addresses and data kept as parameters
  always_comb
  begin
    step = '0;
    unique case (idx)
      3'h0: step = '{UNLOCK_A0, UNLOCK_D0};
      3'h1: step = '{UNLOCK_A1, UNLOCK_D1};
      3'h2: step = '{UNLOCK_A0, clear ? CLEAR_D2 : UNLOCK_D2};
      3'h3: step = '{UNLOCK_A0, UNLOCK_D0};
      3'h4: step = '{UNLOCK_A1, UNLOCK_D1};
      3'h5: step = '{UNLOCK_A0, CLEAR_D5};
      default: step = '0;
    endcase
  end
endmodule : peepw_seq_rom

// File: peepw_host.sv
`timescale 1ns/1ns
`include "peepw_consts.svh"
module peepw_host
#(
  parameter int LOAD_CYC = `PEEPW_LOAD_CYC,
  parameter int WC_CYC = `PEEPW_WC_CYC
)
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reqValid,
  output logic reqReady,
  input peepw_pkg::peepw_req_s req,
  input wire logic protect,
  input wire logic unprotect,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic busy,
  output logic [12:0] memAddr,
  output logic [7:0] memDataOut,
  output logic memDataOe,
  input wire logic [7:0] memDataIn,
  output logic memCeN,
  output logic memOeN,
  output logic memWeN
);
  typedef struct packed
  {
    peepw_pkg::peepw_state_e st;
    peepw_pkg::peepw_pins_s pins;
    peepw_pkg::peepw_op_e op;
    logic [7:0] lastData;
    logic [12:0] lastAddr;
    logic [6:0] pageBase;
    logic [6:0] loadCnt;
    logic [2:0] seqIdx;
    logic [2:0] seqLen;
    logic seqClear;
    logic inPage;
    logic last;
    logic prevToggle;
    logic pollFirst;
    logic [7:0] rdata;
    logic rvalid;
    logic [23:0] cnt;
    logic [23:0] loadTmr;
    logic [23:0] wcTmr;
  } peepw_host_s;
  peepw_host_s s_r;
  peepw_host_s s_nxt;
  peepw_pkg::peepw_step_s step;
  logic seqActive;
  logic startOk;
  function automatic logic samePage(input logic [6:0] base, input logic [12:0] a);
    samePage = (a[12:`PEEPW_PAGE_LSB] == base);
  endfunction : samePage
  peepw_seq_rom u_rom
  (
    .clear(s_r.seqClear),
    .idx(s_r.seqIdx),
    .step(step)
  );
  assign seqActive = (s_r.seqIdx != s_r.seqLen);
  // New page loads must stay in the page and in the load window
  assign startOk = !s_r.inPage || (req.op != peepw_pkg::OP_WRITE)
    || (samePage(s_r.pageBase, req.addr) && s_r.loadCnt < 7'(`PEEPW_PAGE_BYTES));
  assign reqReady = (s_r.st == peepw_pkg::ST_IDLE) && !seqActive && !protect && !unprotect
    && startOk && !(s_r.inPage && req.op != peepw_pkg::OP_WRITE)
    && !(s_r.inPage && (s_r.last || s_r.loadTmr == 24'h0));
  assign busy = (s_r.st != peepw_pkg::ST_IDLE) || seqActive || s_r.inPage;
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    if (s_r.loadTmr != 24'h0)
      s_nxt.loadTmr = s_r.loadTmr - 24'h1;
    if (s_r.wcTmr != 24'h0)
      s_nxt.wcTmr = s_r.wcTmr - 24'h1;
    unique case (s_r.st)
      peepw_pkg::ST_IDLE:
      begin
        s_nxt.pins.ceN = 1'b1;
        s_nxt.pins.oeN = 1'b1;
        s_nxt.pins.weN = 1'b1;
        s_nxt.pins.dataOe = 1'b0;
        if (s_r.inPage && (s_r.last || s_r.loadTmr == 24'h0))
        begin
          // Page closes; wait out programming by polling
          s_nxt.inPage = 1'b0;
          s_nxt.op = peepw_pkg::OP_POLL;
          s_nxt.pins.addr = s_r.lastAddr;
          s_nxt.pollFirst = 1'b1;
          s_nxt.cnt = 24'h0;
          s_nxt.wcTmr = 24'(WC_CYC);
          s_nxt.st = peepw_pkg::ST_WAIT;
        end
        else if (seqActive)
        begin
          s_nxt.op = peepw_pkg::OP_WRITE;
          s_nxt.pins.addr = step.addr;
          s_nxt.pins.dataOut = step.data;
          s_nxt.cnt = 24'(`PEEPW_SETUP_CYC);
          s_nxt.st = peepw_pkg::ST_SETUP;
        end
        else if (protect || unprotect)
        begin
          s_nxt.seqIdx = 3'h0;
          s_nxt.seqLen = unprotect ? 3'h6 : 3'h3;
          s_nxt.seqClear = unprotect;
        end
        else if (reqValid && reqReady)
        begin
          s_nxt.op = req.op;
          s_nxt.last = req.last;
          s_nxt.pins.addr = req.addr;
          s_nxt.pins.dataOut = req.data;
          s_nxt.cnt = 24'(`PEEPW_SETUP_CYC);
          s_nxt.st = peepw_pkg::ST_SETUP;
        end
      end
      peepw_pkg::ST_SETUP:
      begin
        // Output enable high before the write strobe falls
        s_nxt.pins.dataOe = (s_r.op == peepw_pkg::OP_WRITE);
        s_nxt.cnt = s_r.cnt - 24'h1;
        if (s_r.cnt <= 24'h1)
        begin
          s_nxt.pins.ceN = 1'b0;
          if (s_r.op == peepw_pkg::OP_WRITE)
          begin
            s_nxt.pins.weN = 1'b0;
            s_nxt.cnt = 24'(`PEEPW_STROBE_CYC);
            s_nxt.loadTmr = 24'(LOAD_CYC - `PEEPW_LOAD_GUARD);
          end
          else
          begin
            s_nxt.pins.oeN = 1'b0;
            s_nxt.cnt = 24'(`PEEPW_READ_CYC);
          end
          s_nxt.st = peepw_pkg::ST_STROBE;
        end
      end
      peepw_pkg::ST_STROBE:
      begin
        s_nxt.cnt = s_r.cnt - 24'h1;
        if (s_r.cnt <= 24'h1)
        begin
          s_nxt.pins.weN = 1'b1;
          s_nxt.pins.oeN = 1'b1;
          s_nxt.pins.ceN = 1'b1;
          s_nxt.rdata = memDataIn;
          s_nxt.st = peepw_pkg::ST_HOLD;
        end
      end
      peepw_pkg::ST_HOLD:
      begin
        s_nxt.pins.dataOe = 1'b0;
        s_nxt.st = peepw_pkg::ST_IDLE;
        if (s_r.op == peepw_pkg::OP_WRITE)
        begin
          if (seqActive)
          begin
            s_nxt.seqIdx = s_r.seqIdx + 3'h1;
            if (s_r.seqClear && s_r.seqIdx == 3'h5)
            begin
              s_nxt.op = peepw_pkg::OP_POLL;
              s_nxt.pollFirst = 1'b0;
              s_nxt.wcTmr = 24'(WC_CYC);
              s_nxt.st = peepw_pkg::ST_WAIT;
            end
          end
          else
          begin
            if (!s_r.inPage)
              s_nxt.pageBase = s_r.pins.addr[12:`PEEPW_PAGE_LSB];
            s_nxt.loadCnt = s_r.inPage ? s_r.loadCnt + 7'h1 : 7'h1;
            s_nxt.inPage = 1'b1;
            s_nxt.lastAddr = s_r.pins.addr;
            s_nxt.lastData = s_r.pins.dataOut;
          end
        end
        else if (s_r.op == peepw_pkg::OP_READ)
        begin
          s_nxt.rvalid = 1'b1;
        end
        else
        begin
          s_nxt.st = peepw_pkg::ST_POLL;
        end
      end
      peepw_pkg::ST_POLL:
      begin
        // Done when polling bit matches the last written data and toggle bit stops toggling
        s_nxt.prevToggle = s_r.rdata[`PEEPW_TOGGLE_BIT];
        s_nxt.pollFirst = 1'b0;
        s_nxt.cnt = 24'hFF;
        if (!s_r.pollFirst && s_r.rdata[`PEEPW_POLL_BIT] == s_r.lastData[`PEEPW_POLL_BIT]
          && s_r.rdata[`PEEPW_TOGGLE_BIT] == s_r.prevToggle)
          s_nxt.wcTmr = 24'h0;
        s_nxt.st = peepw_pkg::ST_WAIT;
      end
      peepw_pkg::ST_WAIT:
      begin
        // Wait 256 cycles between polls, with no polling after the clear sequence; the write cycle timer bounds the wait
        s_nxt.cnt = s_r.cnt - 24'h1;
        if (s_r.wcTmr <= 24'h1)
        begin
          s_nxt.seqClear = 1'b0;
          s_nxt.st = peepw_pkg::ST_IDLE;
        end
        else if (!s_r.seqClear && (s_r.pollFirst || s_r.cnt[7:0] == 8'h0))
        begin
          s_nxt.pins.addr = s_r.lastAddr;
          s_nxt.cnt = 24'(`PEEPW_SETUP_CYC);
          s_nxt.st = peepw_pkg::ST_SETUP;
        end
      end
      default: s_nxt.st = peepw_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
      s_r.pins.ceN <= 1'b1;
      s_r.pins.oeN <= 1'b1;
      s_r.pins.weN <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end
  assign memAddr = s_r.pins.addr;
  assign memDataOut = s_r.pins.dataOut;
  assign memDataOe = s_r.pins.dataOe;
  assign memCeN = s_r.pins.ceN;
  assign memOeN = s_r.pins.oeN;
  assign memWeN = s_r.pins.weN;
  assign rspValid = s_r.rvalid;
  assign rspData = s_r.rdata;
  a_no_write_oe_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    !memWeN |-> memOeN && !memCeN) else $error("Write strobe with output enable low");
  a_oe_needs_ce: assert property (@(posedge ref_clk) disable iff (!rstn)
    !memOeN |-> !memCeN) else $error("Output enable without chip enable");
  a_no_drive_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    !memOeN |-> !memDataOe) else $error("Host drives bus during read");
  a_we_width: assert property (@(posedge ref_clk) disable iff (!rstn)
    $fell(memWeN) |-> !memWeN [*8]) else $error("Write strobe too short");
  a_data_stable: assert property (@(posedge ref_clk) disable iff (!rstn)
    !memWeN |=> $stable(memDataOut) || memWeN) else $error("Data changed under strobe");
  a_addr_stable: assert property (@(posedge ref_clk) disable iff (!rstn)
    !memWeN && !$fell(memWeN) |-> $stable(memAddr)) else $error("Address moved in write");
  a_rsp_after_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    rspValid |-> $past(memOeN) && $past(s_r.op == peepw_pkg::OP_READ, 2))
    else $error("Response without read");
  a_page_count: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_r.loadCnt <= 7'(`PEEPW_PAGE_BYTES)) else $error("Page overrun");
  a_page_same: assert property (@(posedge ref_clk) disable iff (!rstn)
    s_r.inPage && !memWeN && !seqActive |-> samePage(s_r.pageBase, memAddr))
    else $error("Page address changed");
  a_take_starts: assert property (@(posedge ref_clk) disable iff (!rstn)
    reqValid && reqReady |=> s_r.st == peepw_pkg::ST_SETUP)
    else $error("Accepted request not started");
  c_read: cover property (@(posedge ref_clk) disable iff (!rstn) rspValid);
  c_page2: cover property (@(posedge ref_clk) disable iff (!rstn) s_r.loadCnt == 7'h2);
  c_poll: cover property (@(posedge ref_clk) disable iff (!rstn) s_r.st == peepw_pkg::ST_POLL);
  c_unlock: cover property (@(posedge ref_clk) disable iff (!rstn) s_r.seqIdx == 3'h3);
endmodule : peepw_host

// File: peepw_mem_model.sv
`timescale 1ns/1ns
module peepw_mem_model
#(
  parameter int WIN_CYC = 520,
  parameter int PROG_CYC = 500
)
(
  input wire logic ref_clk,
  input wire logic [12:0] addr,
  input wire logic [7:0] dataOut,
  input wire logic dataOe,
  input wire logic ceN,
  input wire logic oeN,
  input wire logic weN,
  output logic [7:0] busLevel
);
  localparam logic [12:0] SA = 13'h1555;
  localparam logic [12:0] SB = 13'h0AAA;
  logic [7:0] mem [0:8191];
  peepw_pkg::peepw_step_s loadQ [$];
  logic [12:0] latAddr = '0;
  logic [7:0] lastData = 8'hFF, rdData = 8'hFF, lastLevel = 8'hFF;
  logic wrPrev = 1'b0, rdPrev = 1'b0, tog = 1'b0, clearPend = 1'b0;
  logic locked = 1'b0;
  int winCnt = 0;
  int progCnt = 0;
  wire wrOn = !ceN && !weN && oeN;
  wire rdOn = !ceN && !oeN;
  // Released bus shows the inverse of its last level, never a stale copy
  assign busLevel = dataOe ? dataOut : (rdOn ? rdData : ~lastLevel);
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'hFF;
  end
  function automatic bit seqAt(input int i, input logic [12:0] a, input logic [7:0] d);
    return loadQ.size() > i && loadQ[i] === {a, d};
  endfunction : seqAt
  task automatic commitLoad();
    bit unl;
    bit clr;
    unl = seqAt(0, SA, 8'hAA) && seqAt(1, SB, 8'h55) && seqAt(2, SA, 8'hA0);
    clr = seqAt(0, SA, 8'hAA) && seqAt(1, SB, 8'h55) && seqAt(2, SA, 8'h80)
      && seqAt(3, SA, 8'hAA) && seqAt(4, SB, 8'h55) && seqAt(5, SA, 8'h20);
    if (clr || unl || !locked)
      progCnt = PROG_CYC;
    clearPend = clr;
    for (int i = unl ? 3 : 0; i < loadQ.size(); i++)
    begin
      if (!clr && (unl || !locked))
      begin
        mem[loadQ[i].addr] = loadQ[i].data;
        lastData = loadQ[i].data;
      end
    end
    locked = locked || unl;
    loadQ.delete();
  endtask : commitLoad
  always @(posedge ref_clk)
  begin
    wrPrev <= wrOn;
    rdPrev <= rdOn;
    lastLevel <= busLevel;
    if (progCnt == 1 && clearPend)
      locked = 1'b0;
    if (progCnt > 0)
      progCnt = progCnt - 1;
    if (winCnt == 1)
      commitLoad();
    if (winCnt > 0)
      winCnt = winCnt - 1;
    if (wrOn && !wrPrev && progCnt == 0)
    begin
      latAddr <= addr;
      winCnt = WIN_CYC;
    end
    if (!wrOn && wrPrev && progCnt == 0)
      loadQ.push_back({latAddr, dataOut});
    if (rdOn && !rdPrev)
    begin
      rdData <= progCnt > 0 ? {~lastData[7], tog, lastData[5:0]} : mem[addr];
      tog = tog ^ (progCnt > 0);
    end
  end
endmodule : peepw_mem_model

// File: parallel_eeprom_page_write_port_test.sv
`timescale 1ns/1ns
module parallel_eeprom_page_write_port_test;
  localparam int CEIL = 60000;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic reqValid = 1'b0, protect = 1'b0, unprotect = 1'b0;
  peepw_pkg::peepw_req_s req = '0;
  logic reqReady, rspValid, busy, memDataOe, memCeN, memOeN, memWeN;
  logic [7:0] rspData, memDataOut, memDataIn;
  logic [12:0] memAddr;
  int miscompares = 0;
  int cmpCount = 0;
  int cycles = 0;
  always #5 ref_clk = ~ref_clk;
  peepw_host #(.LOAD_CYC(1000), .WC_CYC(2000)) dut_u
  (
    .ref_clk, .rstn, .reqValid, .reqReady, .req, .protect, .unprotect, .rspValid, .rspData,
    .busy, .memAddr, .memDataOut, .memDataOe, .memDataIn, .memCeN, .memOeN, .memWeN
  );
  peepw_mem_model mem_u
  (
    .ref_clk, .addr(memAddr), .dataOut(memDataOut), .dataOe(memDataOe), .ceN(memCeN),
    .oeN(memOeN), .weN(memWeN), .busLevel(memDataIn)
  );
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic issue(input peepw_pkg::peepw_op_e op, input logic [12:0] a,
    input logic [7:0] d, input logic last);
    int g = 0;
    @(posedge ref_clk);
    reqValid <= 1'b1;
    req <= '{op, a, d, last};
    do
      @(negedge ref_clk);
    while (reqReady !== 1'b1 && ++g < 40000);
    @(posedge ref_clk);
    reqValid <= 1'b0;
  endtask : issue
  task automatic waitIdle(output int n);
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end
    while (busy !== 1'b0 && n < 20000);
  endtask : waitIdle
  task automatic writeWait(input logic [12:0] a, input logic [7:0] d, output int n);
    issue(peepw_pkg::OP_WRITE, a, d, 1'b1);
    waitIdle(n);
  endtask : writeWait
  task automatic readCheck(input logic [12:0] a, input logic [7:0] exp);
    int g = 0;
    issue(peepw_pkg::OP_READ, a, 8'h00, 1'b0);
    do
    begin
      @(negedge ref_clk);
      g++;
    end
    while (rspValid !== 1'b1 && g < 60);
    check({7'h0, rspValid}, 8'h01);
    check(rspData, exp);
  endtask : readCheck
  task automatic pulseSeq(input logic clr);
    @(posedge ref_clk);
    protect <= !clr;
    unprotect <= clr;
    @(posedge ref_clk);
    protect <= 1'b0;
    unprotect <= 1'b0;
  endtask : pulseSeq
  task automatic t_reset();
    check({4'h0, memCeN, memOeN, memWeN, memDataOe}, 8'h0E);
    check({7'h0, busy}, 8'h00);
    $display("reset test done");
  endtask : t_reset
  task automatic t_byte();
    int n;
    writeWait(13'h0040, 8'h5A, n);
    check({7'h0, n < 2200}, 8'h01);
    readCheck(13'h0040, 8'h5A);
    $display("byte write test done");
  endtask : t_byte
  task automatic t_page();
    int n;
    for (int i = 0; i < 64; i++)
      issue(peepw_pkg::OP_WRITE, 13'h0100 + 13'(i), 8'(i), 1'b0);
    waitIdle(n);
    for (int i = 0; i < 64; i++)
      readCheck(13'h0100 + 13'(i), 8'(i));
    issue(peepw_pkg::OP_WRITE, 13'h0200, 8'h21, 1'b0);
    writeWait(13'h0240, 8'h22, n);
    readCheck(13'h0200, 8'h21);
    readCheck(13'h0240, 8'h22);
    $display("page write test done");
  endtask : t_page
  task automatic t_protect();
    int n;
    pulseSeq(1'b0);
    writeWait(13'h0300, 8'h33, n);
    readCheck(13'h0300, 8'h33);
    writeWait(13'h0301, 8'h44, n);
    readCheck(13'h0301, 8'hFF);
    pulseSeq(1'b1);
    waitIdle(n);
    writeWait(13'h0301, 8'h45, n);
    readCheck(13'h0301, 8'h45);
    $display("protection test done");
  endtask : t_protect
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      miscompares++;
      $display("unexpected timeout at %0t ns", $time);
      complete_run();
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    t_reset();
    @(posedge ref_clk);
    rstn <= 1'b1;
    t_byte();
    t_page();
    t_protect();
    complete_run();
  end
endmodule : parallel_eeprom_page_write_port_test
